// *** verilog/swse_cfg.svh ***
// Purpose: constants for the sleep/watchdog/subtract execution block
// Assumes: 14-bit opcode word, 8-bit working register
// Notes: register map of the plain software port lives here too
`ifndef SWSE_CFG_SVH
`define SWSE_CFG_SVH
`define SWSE_OP_W 14
`define SWSE_CLEAR_WORK_REG_OP_MASK 14'h3f80
`define SWSE_CLEAR_WORK_REG_OP_CODE 14'h0100
`define SWSE_CLEAR_WATCHDOG_OP_CODE 14'h0064
`define SWSE_SLEEP_CODE 14'h0063
`define SWSE_SUB_MASK 14'h3e00
`define SWSE_SUB_CODE 14'h3c00
`define SWSE_ADDR_CTRL 4'h0
`define SWSE_ADDR_STAT 4'h1
`define SWSE_ADDR_IRQ 4'h2
`define SWSE_ADDR_MASK 4'h3
`define SWSE_ADDR_WREG 4'h4
`define SWSE_ADDR_WDT 4'h5
`define SWSE_IRQ_SLEEP 0
`define SWSE_IRQ_CLEAR_WATCHDOG_OP 1
`define SWSE_IRQ_SUB 2
`define SWSE_IRQ_CLEAR_WORK_REG_OP 3
`define SWSE_FLAG_RESET 5'h18
`define SWSE_CTRL_CLR 0
`define SWSE_CTRL_EN 1
`define SWSE_LIT_W 8
`endif

// *** verilog/swse_pkg.sv ***
// Purpose: types for the execution block
// Assumes: swse_cfg.svh constants
// Notes: flags packed as time-out, power-down, zero, digit carry, carry
package swse_pkg;
  typedef enum logic [1:0] {SWSE_Q1, SWSE_Q2, SWSE_Q3, SWSE_Q4} swse_phase_t;
  typedef enum logic [2:0] {SWSE_NONE, SWSE_CLEAR_WORK_REG_OP, SWSE_CLEAR_WATCHDOG_OP, SWSE_SLEEP,
                            SWSE_SUB} swse_op_t;
  typedef struct packed {
    logic time_out_flag;
    logic power_down_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } swse_flags_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } swse_bus_t;
endpackage

// *** verilog/swse_decode.sv ***
// Purpose: opcode decode for the execution block
// Assumes: opcode stable across one instruction cycle
// Notes: pure combinational
`timescale 1ns/1ps
`include "swse_cfg.svh"
module swse_decode (
  // opcode in
  input wire logic [`SWSE_OP_W-1:0] opcode,
  // decoded op
  output swse_pkg::swse_op_t op
);
  import swse_pkg::*;
  wire is_clear_work_reg_op = (opcode & `SWSE_CLEAR_WORK_REG_OP_MASK) == `SWSE_CLEAR_WORK_REG_OP_CODE;
  wire is_clear_watchdog_op = opcode == `SWSE_CLEAR_WATCHDOG_OP_CODE;
  wire is_sleep = opcode == `SWSE_SLEEP_CODE;
  wire is_sub = (opcode & `SWSE_SUB_MASK) == `SWSE_SUB_CODE;
  assign op = is_clear_work_reg_op ? SWSE_CLEAR_WORK_REG_OP : is_clear_watchdog_op ? SWSE_CLEAR_WATCHDOG_OP : is_sleep ? SWSE_SLEEP :
              is_sub ? SWSE_SUB : SWSE_NONE;
endmodule // swse_decode

// *** verilog/swse_sub.sv ***
// Purpose: literal minus w with carry, digit carry and zero
// Assumes: 8-bit operands
// Notes: carry and digit carry are inverted borrows
`timescale 1ns/1ps
module swse_sub #(
  parameter int WIDTH = 8
) (
  // operands
  input wire logic [WIDTH-1:0] literal,
  input wire logic [WIDTH-1:0] work,
  // result
  output logic [WIDTH-1:0] diff,
  output logic carry,
  output logic digit_carry,
  output logic zero
);
  wire [WIDTH:0] full = {1'b0, literal} + {1'b0, ~work} + {{WIDTH{1'b0}}, 1'b1};
  wire [4:0] low = {1'b0, literal[3:0]} + {1'b0, ~work[3:0]} + 5'h01;
  assign diff = full[WIDTH-1:0];
  assign carry = full[WIDTH];
  assign digit_carry = low[4];
  assign zero = diff == '0;
endmodule // swse_sub

// *** verilog/swse_core.sv ***
// Purpose: execute clear-work, clear-watchdog, sleep and subtract-from-literal
// Assumes: instruction presented with quarter phase one, one phase per enabled clock
// Notes: opcode input comes from the fetch stage on the same clock
`timescale 1ns/1ps
`include "swse_cfg.svh"
module swse_core #(
  parameter int WDT_W = 8,
  parameter int PRE_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // instruction
  input wire logic [`SWSE_OP_W-1:0] opcode,
  input wire logic wake_pin,
  // software port
  input wire swse_pkg::swse_bus_t bus,
  output logic [7:0] rdata_ff,
  // state out
  output swse_pkg::swse_phase_t phase_ff,
  output logic [7:0] work_ff,
  output swse_pkg::swse_flags_t flags_ff,
  output logic sleeping_ff,
  output logic [WDT_W-1:0] watchdog_counter_ff,
  output logic irq_ff
);
  import swse_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode and arithmetic
  swse_op_t op;
  swse_op_t op_ff;
  logic [7:0] literal_ff;
  logic [7:0] diff_ff;
  swse_flags_t res_ff;
  logic [PRE_W-1:0] pre_ff;
  logic [7:0] ctrl_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic wake_s1_ff;
  logic wake_s2_ff;
  logic [7:0] diff;
  logic sub_c;
  logic sub_dc;
  logic sub_z;

  swse_decode u_dec (
    .opcode(opcode),
    .op(op)
  );

  swse_sub #(.WIDTH(8)) u_sub (
    .literal(literal_ff),
    .work(work_ff),
    .diff(diff),
    .carry(sub_c),
    .digit_carry(sub_dc),
    .zero(sub_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  // phase and event decode
  wire run = clk_en && !sleeping_ff;
  wire in_q1 = phase_ff == SWSE_Q1;
  wire in_q2 = phase_ff == SWSE_Q2;
  wire in_q3 = phase_ff == SWSE_Q3;
  wire in_q4 = phase_ff == SWSE_Q4;
  wire wdt_clr = in_q4 && (op_ff == SWSE_CLEAR_WATCHDOG_OP || op_ff == SWSE_SLEEP);
  wire go_sleep = in_q4 && op_ff == SWSE_SLEEP;
  wire w_write = in_q4 && (op_ff == SWSE_CLEAR_WORK_REG_OP || op_ff == SWSE_SUB);
  wire [3:0] ev;
  assign ev[`SWSE_IRQ_SLEEP] = go_sleep;
  assign ev[`SWSE_IRQ_CLEAR_WATCHDOG_OP] = in_q4 && op_ff == SWSE_CLEAR_WATCHDOG_OP;
  assign ev[`SWSE_IRQ_SUB] = w_write && op_ff == SWSE_SUB;
  assign ev[`SWSE_IRQ_CLEAR_WORK_REG_OP] = w_write && op_ff == SWSE_CLEAR_WORK_REG_OP;
  wire [3:0] ev_run = run ? ev : 4'h0;
  wire rd_stat = bus.rd && bus.addr == `SWSE_ADDR_IRQ;
  wire [3:0] nxt_irq_stat = ev_run | (rd_stat ? 4'h0 : irq_stat_ff);
  wire [3:0] nxt_irq_mask = (bus.wr && bus.addr == `SWSE_ADDR_MASK) ? bus.wdata[3:0] : irq_mask_ff;
  wire sw_wdt_clr = bus.wr && bus.addr == `SWSE_ADDR_CTRL && bus.wdata[`SWSE_CTRL_CLR];
  wire [WDT_W-1:0] wdt_inc = watchdog_counter_ff + {{(WDT_W-1){1'b0}}, 1'b1};
  wire [PRE_W-1:0] pre_inc = pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};

  function automatic logic [7:0] rd_mux(input logic [3:0] a);
    case (a)
      `SWSE_ADDR_CTRL: rd_mux = ctrl_ff;
      `SWSE_ADDR_STAT: rd_mux = {3'h0, flags_ff};
      `SWSE_ADDR_IRQ: rd_mux = {4'h0, irq_stat_ff};
      `SWSE_ADDR_MASK: rd_mux = {4'h0, irq_mask_ff};
      `SWSE_ADDR_WREG: rd_mux = work_ff;
      `SWSE_ADDR_WDT: rd_mux = watchdog_counter_ff[7:0];
      default: rd_mux = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pipeline: decode q1, literal q2, compute q3
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phase_ff <= SWSE_Q1;
      op_ff <= SWSE_NONE;
      literal_ff <= 8'h00;
      diff_ff <= 8'h00;
      res_ff <= `SWSE_FLAG_RESET;
    end else if (run) begin
      case (phase_ff)
        SWSE_Q1: phase_ff <= SWSE_Q2;
        SWSE_Q2: phase_ff <= SWSE_Q3;
        SWSE_Q3: phase_ff <= SWSE_Q4;
        SWSE_Q4: phase_ff <= SWSE_Q1;
        default: phase_ff <= SWSE_Q1;
      endcase
      if (in_q1) op_ff <= op;
      if (in_q2) literal_ff <= opcode[`SWSE_LIT_W-1:0];
      if (in_q3) begin
        diff_ff <= (op_ff == SWSE_SUB) ? diff : 8'h00;
        res_ff <= flags_ff;
        if (op_ff == SWSE_SUB) begin
          res_ff.carry <= sub_c;
          res_ff.digit_carry_flag <= sub_dc;
          res_ff.zero <= sub_z;
        end else if (op_ff == SWSE_CLEAR_WORK_REG_OP) begin
          res_ff.zero <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working register, flags, sleep
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      work_ff <= 8'h00;
      flags_ff <= `SWSE_FLAG_RESET;
      sleeping_ff <= 1'b0;
    end else if (clk_en) begin
      if (run && w_write) begin
        work_ff <= diff_ff;
        flags_ff <= res_ff;
      end
      if (run && in_q4 && op_ff == SWSE_CLEAR_WATCHDOG_OP) begin
        flags_ff.time_out_flag <= 1'b1;
        flags_ff.power_down_flag <= 1'b1;
      end
      if (run && go_sleep) begin
        flags_ff.power_down_flag <= 1'b0;
        flags_ff.time_out_flag <= 1'b1;
        sleeping_ff <= 1'b1;
      end else if (sleeping_ff && wake_s2_ff) begin
        sleeping_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog counter and prescaler
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      watchdog_counter_ff <= '0;
      pre_ff <= '0;
    end else if (clk_en) begin
      if ((run && wdt_clr) || sw_wdt_clr) begin
        watchdog_counter_ff <= '0;
        pre_ff <= '0;
      end else if (ctrl_ff[`SWSE_CTRL_EN]) begin
        pre_ff <= pre_inc;
        if (&pre_ff) watchdog_counter_ff <= wdt_inc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software port, wake synchroniser, interrupt
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= 8'h00;
      irq_mask_ff <= 4'h0;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
      wake_s1_ff <= 1'b0;
      wake_s2_ff <= 1'b0;
    end else if (clk_en) begin
      wake_s1_ff <= wake_pin;
      wake_s2_ff <= wake_s1_ff;
      if (bus.wr && bus.addr == `SWSE_ADDR_CTRL) begin
        ctrl_ff <= {6'h00, bus.wdata[`SWSE_CTRL_EN], 1'b0};
      end
      irq_mask_ff <= nxt_irq_mask;
      rdata_ff <= bus.rd ? rd_mux(bus.addr) : 8'h00;
      irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt status, one flop per event
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          irq_stat_ff[gi] <= 1'b0;
        end else if (clk_en) begin
          irq_stat_ff[gi] <= nxt_irq_stat[gi];
        end
      end
      a_irq_set_wins: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && ev_run[gi] |=> irq_stat_ff[gi]) else $error("irq event lost");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_sleep_q4;
    run && go_sleep;
  endsequence
  sequence s_asleep;
    sleeping_ff && !flags_ff.power_down_flag && flags_ff.time_out_flag;
  endsequence

  a_sleep_flags: assert property (@(posedge sys_clk) disable iff (reset)
    s_sleep_q4 |=> s_asleep) else $error("sleep flags wrong");
  a_sleep_to_set: assert property (@(posedge sys_clk) disable iff (reset)
    s_sleep_q4 |=> flags_ff.time_out_flag) else $error("time-out not set");
  a_sleep_wdt_zero: assert property (@(posedge sys_clk) disable iff (reset)
    s_sleep_q4 |=> watchdog_counter_ff == '0 && pre_ff == '0)
    else $error("watchdog not cleared");
  a_sleep_halts: assert property (@(posedge sys_clk) disable iff (reset)
    sleeping_ff && !wake_s2_ff && clk_en |=> $stable(phase_ff) && $stable(work_ff))
    else $error("core ran in sleep");
  a_sleep_only_q4: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(sleeping_ff) |-> $past(phase_ff) == SWSE_Q4) else $error("sleep off q4");
  a_w_write_q4: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(work_ff) |-> $past(phase_ff) == SWSE_Q4) else $error("w written off q4");
  a_clear_work_reg_op_zero: assert property (@(posedge sys_clk) disable iff (reset)
    run && w_write && op_ff == SWSE_CLEAR_WORK_REG_OP |=> work_ff == 8'h00 && flags_ff.zero)
    else $error("clear-work result wrong");
  a_clear_watchdog_op_flags: assert property (@(posedge sys_clk) disable iff (reset)
    run && in_q4 && op_ff == SWSE_CLEAR_WATCHDOG_OP |=> flags_ff.time_out_flag &&
    flags_ff.power_down_flag && watchdog_counter_ff == '0) else $error("clear-watchdog wrong");
  a_sub_result: assert property (@(posedge sys_clk) disable iff (reset)
    run && in_q2 && op_ff == SWSE_SUB ##2 run && in_q4 |=>
    work_ff == $past(literal_ff, 1) - $past(work_ff, 1)) else $error("subtract result wrong");
  a_sub_flags: assert property (@(posedge sys_clk) disable iff (reset)
    run && w_write && op_ff == SWSE_SUB |=>
    flags_ff.carry == ($past(literal_ff) >= $past(work_ff))) else $error("carry not inverted borrow");
  a_sub_keeps: assert property (@(posedge sys_clk) disable iff (reset)
    run && w_write && op_ff == SWSE_SUB |=>
    flags_ff.time_out_flag == $past(flags_ff.time_out_flag)) else $error("subtract hit flags");
  a_sub_keeps_pd: assert property (@(posedge sys_clk) disable iff (reset)
    run && w_write && op_ff == SWSE_SUB |=>
    flags_ff.power_down_flag == $past(flags_ff.power_down_flag)) else $error("subtract hit pd");
  a_sub_dc: assert property (@(posedge sys_clk) disable iff (reset)
    run && w_write && op_ff == SWSE_SUB |=> flags_ff.digit_carry_flag ==
    ($past(literal_ff[3:0]) >= $past(work_ff[3:0]))) else $error("digit carry wrong");
  a_sub_zero: assert property (@(posedge sys_clk) disable iff (reset)
    run && w_write && op_ff == SWSE_SUB |=> flags_ff.zero == (work_ff == 8'h00))
    else $error("zero flag wrong");

  ////////////////////////////////////////////////////////////////////////////
  // subtract steps
  sequence s_sub_compute;
    run && in_q3 && op_ff == SWSE_SUB;
  endsequence
  a_sub_diff: assert property (@(posedge sys_clk) disable iff (reset)
    s_sub_compute |=> diff_ff == $past(literal_ff) - $past(work_ff))
    else $error("difference wrong");
  a_lit_latch: assert property (@(posedge sys_clk) disable iff (reset)
    run && in_q2 |=> literal_ff == $past(opcode[`SWSE_LIT_W-1:0]))
    else $error("literal not taken in q2");

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencing and decode
  a_phase_q1q2: assert property (@(posedge sys_clk) disable iff (reset)
    run && in_q1 |=> in_q2)
    else $error("phase q1 stuck");
  a_phase_q2q3: assert property (@(posedge sys_clk) disable iff (reset)
    run && in_q2 |=> in_q3)
    else $error("phase q2 stuck");
  a_phase_q3q4: assert property (@(posedge sys_clk) disable iff (reset)
    run && in_q3 |=> in_q4)
    else $error("phase q3 stuck");
  a_phase_q4q1: assert property (@(posedge sys_clk) disable iff (reset)
    run && in_q4 |=> in_q1)
    else $error("phase q4 stuck");
  a_op_latch: assert property (@(posedge sys_clk) disable iff (reset)
    run && in_q1 |=> op_ff == $past(op))
    else $error("op not taken in q1");
  a_clear_work_reg_op_decode: assert property (@(posedge sys_clk) disable iff (reset)
    (opcode & `SWSE_CLEAR_WORK_REG_OP_MASK) == `SWSE_CLEAR_WORK_REG_OP_CODE |-> op == SWSE_CLEAR_WORK_REG_OP)
    else $error("clear-work not decoded");
  a_sleep_decode: assert property (@(posedge sys_clk) disable iff (reset)
    op == SWSE_SLEEP |-> opcode == `SWSE_SLEEP_CODE)
    else $error("sleep decoded wrongly");
  a_sub_decode: assert property (@(posedge sys_clk) disable iff (reset)
    op == SWSE_SUB |-> (opcode & `SWSE_SUB_MASK) == `SWSE_SUB_CODE)
    else $error("subtract decoded wrongly");
  a_nop_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    run && in_q4 && op_ff == SWSE_NONE |=> $stable(work_ff) && $stable(flags_ff))
    else $error("unknown opcode acted");
  a_clear_work_reg_op_keeps: assert property (@(posedge sys_clk) disable iff (reset)
    run && w_write && op_ff == SWSE_CLEAR_WORK_REG_OP |=> flags_ff.carry == $past(flags_ff.carry))
    else $error("clear-work hit carry");
  a_clk_freeze: assert property (@(posedge sys_clk) disable iff (reset)
    !clk_en |=> $stable(phase_ff) && $stable(work_ff) && $stable(flags_ff))
    else $error("state moved while frozen");

  ////////////////////////////////////////////////////////////////////////////
  // sleep, wake and watchdog
  a_sleep_no_w: assert property (@(posedge sys_clk) disable iff (reset)
    run && go_sleep |=> $stable(work_ff))
    else $error("sleep wrote w");
  a_sleep_cause: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(sleeping_ff) |-> $past(op_ff) == SWSE_SLEEP)
    else $error("slept without sleep op");
  a_sleep_q1: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(sleeping_ff) |-> in_q1)
    else $error("sleep left mid instruction");
  a_wake_resume: assert property (@(posedge sys_clk) disable iff (reset)
    sleeping_ff && wake_s2_ff && clk_en |=> !sleeping_ff)
    else $error("wake ignored");
  a_wake_q1: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(sleeping_ff) |-> in_q1)
    else $error("wake off q1");
  a_clear_watchdog_op_pre: assert property (@(posedge sys_clk) disable iff (reset)
    run && in_q4 && op_ff == SWSE_CLEAR_WATCHDOG_OP |=> pre_ff == '0 && $stable(work_ff))
    else $error("prescaler not cleared");
  a_sw_wdt_clr: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && sw_wdt_clr |=> watchdog_counter_ff == '0 && pre_ff == '0)
    else $error("software clear missed");
  a_wdt_hold: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && !ctrl_ff[`SWSE_CTRL_EN] && !sw_wdt_clr && !(run && wdt_clr) |=>
    $stable(watchdog_counter_ff)) else $error("watchdog ran disabled");

  ////////////////////////////////////////////////////////////////////////////
  // software port and interrupt
  a_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
    irq_ff == |(irq_stat_ff & irq_mask_ff))
    else $error("irq level wrong");
  a_irq_rd_clear: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && rd_stat && ev_run == 4'h0 |=> irq_stat_ff == 4'h0)
    else $error("status not cleared by read");
  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && !bus.rd |=> rdata_ff == 8'h00)
    else $error("read data without read");
  a_rdata_stat: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && bus.rd && bus.addr == `SWSE_ADDR_STAT |=> rdata_ff == {3'h0, $past(flags_ff)})
    else $error("flags read wrong");
endmodule // swse_core

// *** verification/tb.sv ***
// Purpose: self-checking bench for the execution block
// Assumes: clk_en held high except for one freeze check; one instruction per four enabled cycles
// Notes: random literals from a fixed seed, corner opcodes by hand
`timescale 1ns/1ps
`include "swse_cfg.svh"
module tb;
  import swse_pkg::*;
  logic sys_clk;
  logic reset;
  logic clk_en;
  logic [`SWSE_OP_W-1:0] opcode;
  logic wake_pin;
  swse_bus_t bus;
  logic [7:0] rdata_ff;
  swse_phase_t phase_ff;
  logic [7:0] work_ff;
  swse_flags_t flags_ff;
  logic sleeping_ff;
  logic [7:0] watchdog_counter_ff;
  logic irq_ff;
  int n_errors;
  int checked;
  int cycles = 0;
  int seed_dummy;
  logic [7:0] w_exp;
  logic [7:0] k;
  swse_flags_t fl_exp;
  logic [13:0] miss [5] = '{14'h0062, 14'h0073, 14'h2063, 14'h3e00, 14'h3a00};

  swse_core #(.WDT_W(8), .PRE_W(2)) u_swse_core (.sys_clk(sys_clk), .reset(reset),
    .clk_en(clk_en), .opcode(opcode), .wake_pin(wake_pin), .bus(bus), .rdata_ff(rdata_ff),
    .phase_ff(phase_ff), .work_ff(work_ff), .flags_ff(flags_ff), .sleeping_ff(sleeping_ff),
    .watchdog_counter_ff(watchdog_counter_ff), .irq_ff(irq_ff));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic swse_flags_t sub_flags(input logic [7:0] lit, input logic [7:0] w,
      input swse_flags_t f);
    swse_flags_t r;
    logic [7:0] d;
    r = f;
    d = lit - w;
    r.carry = (lit >= w);
    r.digit_carry_flag = (lit[3:0] >= w[3:0]);
    r.zero = (d == 8'h00);
    return r;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkf(input swse_flags_t got, input swse_flags_t exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t flags got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic exec(input logic [13:0] op);
    @(negedge sys_clk);
    while (phase_ff !== SWSE_Q4) @(negedge sys_clk);
    @(posedge sys_clk);
    opcode <= op;
    repeat (3) @(posedge sys_clk);
    #1;
    chk8(work_ff, w_exp);
    @(posedge sys_clk);
    opcode <= 14'h0000;
    #1;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus <= '0;
  endtask

  task automatic bus_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    chk8(rdata_ff, e);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    checked = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    opcode = '0;
    wake_pin = 1'b0;
    bus = '0;
    seed_dummy = $urandom(12);
    w_exp = 8'h00;
    fl_exp = 5'h18;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chkf(flags_ff, 5'h18);
    chk8(work_ff, 8'h00);
    // subtract: boundaries then random literals, ignored bit toggled
    for (int i = 0; i < 40; i++) begin
      k = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? w_exp : 8'($urandom);
      exec({5'b11110, i[0], k});
      fl_exp = sub_flags(k, w_exp, fl_exp);
      w_exp = k - w_exp;
      chk8(work_ff, w_exp);
      chkf(flags_ff, fl_exp);
    end
    for (int i = 0; i < 2; i++) begin
      exec(`SWSE_CLEAR_WORK_REG_OP_CODE | 14'($urandom & 32'h7f));
      w_exp = 8'h00;
      fl_exp.zero = 1'b1;
      chk8(work_ff, w_exp);
      chkf(flags_ff, fl_exp);
    end
    foreach (miss[i]) begin
      exec(miss[i]);
      chk1(sleeping_ff, 1'b0);
      chkf(flags_ff, fl_exp);
    end
    @(posedge sys_clk);
    clk_en <= 1'b0;
    @(posedge sys_clk);
    #1;
    k = {6'h00, phase_ff};
    repeat (5) @(posedge sys_clk);
    #1;
    chk8({6'h00, phase_ff}, k);
    chk8(work_ff, w_exp);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    bus_wr(`SWSE_ADDR_CTRL, 8'h02);
    repeat (30) @(posedge sys_clk);
    exec(`SWSE_SLEEP_CODE);
    fl_exp.time_out_flag = 1'b1;
    fl_exp.power_down_flag = 1'b0;
    chk1(sleeping_ff, 1'b1);
    chk8(watchdog_counter_ff, 8'h00);
    chkf(flags_ff, fl_exp);
    @(posedge sys_clk);
    opcode <= 14'h3c55;
    repeat (11) @(posedge sys_clk);
    #1;
    chk8(work_ff, w_exp);
    chk8({6'h00, phase_ff}, 8'h00);
    opcode <= 14'h0000;
    wake_pin <= 1'b1;
    for (int i = 0; i < 10 && sleeping_ff !== 1'b0; i++) @(posedge sys_clk);
    wake_pin <= 1'b0;
    #1;
    chk1(sleeping_ff, 1'b0);
    repeat (30) @(posedge sys_clk);
    #1;
    chk1(watchdog_counter_ff != 8'h00, 1'b1);
    exec(`SWSE_CLEAR_WATCHDOG_OP_CODE);
    fl_exp.power_down_flag = 1'b1;
    chk8(watchdog_counter_ff, 8'h00);
    chkf(flags_ff, fl_exp);
    bus_wr(`SWSE_ADDR_CTRL, 8'h00);
    chk1(irq_ff, 1'b0);
    bus_rd(`SWSE_ADDR_IRQ, 8'h0f);
    bus_rd(`SWSE_ADDR_IRQ, 8'h00);
    bus_wr(`SWSE_ADDR_MASK, 8'h04);
    k = 8'($urandom);
    exec({6'b111100, k});
    fl_exp = sub_flags(k, w_exp, fl_exp);
    w_exp = k - w_exp;
    chk1(irq_ff, 1'b1);
    chk8(work_ff, w_exp);
    chkf(flags_ff, fl_exp);
    bus_rd(`SWSE_ADDR_STAT, {3'h0, fl_exp});
    bus_rd(`SWSE_ADDR_WREG, w_exp);
    bus_rd(`SWSE_ADDR_IRQ, 8'h04);
    chk1(irq_ff, 1'b0);
    tally_and_finish();
  end
endmodule // tb
